//--- rtl/uia_irda.sv
module uia_irda (
  // system
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // settings
  input  wire uia_pkg::uia_ir_cfg_s cfg_i,
  input  wire logic                 tick_i,
  input  wire logic [15:0]          bit_div_i,
  // transmit side
  input  wire logic                 tx_bit_start_i,
  input  wire logic                 tx_bit_i,
  output logic                      tx_light_o,
  // receive side
  input  wire logic                 rx_pin_i,
  output logic                      rx_line_o
);
  import uia_pkg::*;

  logic [5:0]  tx_left;
  logic [5:0]  flt_cnt;
  logic [15:0] stretch;
  logic        hit_prev;
  logic [6:0]  pl_half;
  logic [6:0]  fl_half;
  logic        light;
  logic        hit;

  // pulse lengths are in half periods of the pulse clock, rounded up to whole ticks
  assign pl_half = ({1'b0, cfg_i.tx_pl} + PL_OFS + 7'd1) >> 1;
  assign fl_half = ({1'b0, cfg_i.filt_len} + FL_OFS + 7'd1) >> 1;
  assign light   = rx_pin_i ^ cfg_i.rx_pol;
  assign hit     = light && (!cfg_i.filt_en || ({1'b0, flt_cnt} >= fl_half));

  // a zero bit becomes one short light pulse at the start of its bit
  always_ff @(posedge clk_i) begin
    if (rst_i || !cfg_i.en) begin
      tx_left <= 6'h00;
    end else if (ce_i) begin
      if (tx_bit_start_i && !tx_bit_i) begin
        tx_left <= pl_half[5:0];
      end else if (tick_i && tx_left != 6'h00) begin
        tx_left <= tx_left - 6'h01;
      end
    end
  end
  assign tx_light_o = (tx_left != 6'h00);

  // width of the current light pulse, counted in pulse clock ticks
  // the clear sits under the enable so a frozen block keeps its count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_cnt <= 6'h00;
    end else if (ce_i) begin
      if (!light) begin
        flt_cnt <= 6'h00;
      end else if (tick_i && flt_cnt != 6'h3f) begin
        flt_cnt <= flt_cnt + 6'h01;
      end
    end
  end

  // an accepted pulse is stretched into one low bit time for the receiver
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_prev <= 1'b0;
      stretch  <= 16'h0000;
    end else if (ce_i) begin
      hit_prev <= hit;
      if (hit && !hit_prev) begin
        stretch <= bit_div_i;
      end else if (stretch != 16'h0000) begin
        stretch <= stretch - 16'h0001;
      end
    end
  end
  assign rx_line_o = (stretch == 16'h0000);
endmodule

//--- rtl/uia_pkg.sv
package uia_pkg;
  // register byte offsets on the wishbone port, one aligned word each
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_BAUD  = 8'h04;
  localparam logic [7:0] ADR_RXBUF = 8'h08;
  localparam logic [7:0] ADR_TXBUF = 8'h0c;
  localparam logic [7:0] ADR_ABCTL = 8'h10;
  localparam logic [7:0] ADR_IRCTL = 8'h14;
  localparam logic [7:0] ADR_IE    = 8'h18;
  localparam logic [7:0] ADR_IFG   = 8'h1c;
  localparam logic [7:0] ADR_IV    = 8'h20;
  localparam logic [7:0] ADR_STAT  = 8'h24;

  // control register fields
  localparam int CTL_SWRST = 0;
  localparam int CTL_BRK   = 1;
  localparam int CTL_7BIT  = 2;
  localparam int CTL_OS16  = 3;
  // autobaud control fields
  localparam int AB_DELIM_LSB = 4;
  localparam int AB_STOE      = 3;
  localparam int AB_BTOE      = 2;
  localparam int AB_EN        = 0;
  // infrared control fields
  localparam int IR_FL_LSB = 10;
  localparam int IR_RXPL   = 9;
  localparam int IR_FE     = 8;
  localparam int IR_PL_LSB = 2;
  localparam int IR_CLK    = 1;
  localparam int IR_EN     = 0;
  // interrupt flag and enable positions
  localparam int IFG_TXCPT = 3;
  localparam int IFG_STT   = 2;
  localparam int IFG_TX    = 1;
  localparam int IFG_RX    = 0;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_FE   = 1;
  localparam int ST_OE   = 2;
  localparam int ST_ERR  = 3;

  // reset values and writable masks
  localparam logic [15:0] CTRL_RST  = 16'h0001;
  localparam logic [15:0] BAUD_RST  = 16'h0010;
  localparam logic [3:0]  IFG_RST   = 4'h2;
  localparam logic [15:0] CTRL_WMSK = 16'h000f;
  localparam logic [15:0] AB_WMSK   = 16'h003d;
  localparam logic [15:0] IE_WMSK   = 16'h000f;
  localparam logic [15:0] IV_NONE   = 16'h0000;

  // timing: break lengths in bit times, synch falls and shifts, pulse offsets in half periods
  localparam logic [20:0] BRK_TOUT_BITS = 21'd22;
  localparam logic [20:0] BRK_MIN_BITS  = 21'd11;
  localparam logic [4:0]  BRK_TX_BITS   = 5'd13;
  localparam logic [2:0]  SYNC_FALLS    = 3'd4;
  localparam int          SYNC_SHIFT    = 3;
  localparam int          OS_SHIFT      = 4;
  localparam logic [6:0]  FL_OFS        = 7'd4;
  localparam logic [6:0]  PL_OFS        = 7'd1;

  typedef enum logic [1:0] {TX_IDLE, TX_BREAK, TX_DELIM, TX_FRAME} uia_tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP, AB_BREAK, AB_DELIM, AB_SYNC
  } uia_rx_state_e;

  // infrared codec settings carried as one bundle
  typedef struct packed {
    logic       en;
    logic       rx_pol;
    logic       filt_en;
    logic [5:0] filt_len;
    logic [5:0] tx_pl;
  } uia_ir_cfg_s;
endpackage

//--- rtl/uia_uart.sv
// Summary of operation
// - writing transmit data clears transmit-empty flag
// - seven-bit mode forces data bit seven zero
// - delimiter code gives one to four bits
// - overlong synch field sets synch timeout error
// - break over 22 bits sets break timeout
// - autobaud enable measures break/synch, updates divisor
// - filter rejects pulses below (length+4) half periods
// - polarity bit selects light pulse sense
// - receive filter used only when enabled
// - transmit pulse lasts (length+1) half periods
// - pulse clock oversample tick only when oversampling
// - infrared codec in path only when enabled
// - four interrupt enables, all reset zero
// - transmit complete when shifter done, buffer empty
// - start bit flag set on received start
// - transmit-empty set when buffer empty, resets one
// - receive flag set when character is buffered
// - vector codes by priority, receive highest
// - reading receive buffer clears errors and flag
module uia_uart (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial line
  input  wire logic        serial_in_pin_i,
  output logic             serial_out_pin_o,
  // interrupt request
  output logic             irq_o
);
  import uia_pkg::*;

  logic [15:0]   ctrl;
  logic [15:0]   bit_div;
  logic [15:0]   ab_ctl;
  logic [15:0]   ir_ctl;
  logic [3:0]    int_en;
  logic [3:0]    flags;
  logic [7:0]    tx_buf;
  logic [7:0]    rx_buf;
  logic          tx_full;
  logic          fe;
  logic          oe;
  uia_tx_state_e tx_state;
  uia_rx_state_e rx_state;
  logic [15:0]   tx_cnt;
  logic [4:0]    tx_bits;
  logic [8:0]    tx_shift;
  logic          tx_line;
  logic          tx_bstart;
  logic [20:0]   rx_cnt;
  logic [3:0]    rx_bits;
  logic [7:0]    rx_shift;
  logic [2:0]    ab_falls;
  logic          rx_prev;
  logic [11:0]   os_cnt;
  logic          acc;
  logic          wr;
  logic          rd;
  logic [15:0]   wdat;
  logic [15:0]   rdat;
  logic          soft_rst;
  logic          seven;
  logic [15:0]   div_m1;
  logic          tx_bit_end;
  logic          tx_take;
  logic          brk_take;
  logic          tx_done_set;
  logic          rx_done;
  logic [7:0]    rx_data;
  logic          fe_set;
  logic          start_set;
  logic          btoe_set;
  logic          stoe_set;
  logic          ab_done;
  logic [15:0]   ab_div;
  logic          rx_line;
  logic          fall;
  logic [20:0]   brk_limit;
  logic [20:0]   brk_min;
  logic [20:0]   delim_need;
  logic [2:0]    iv_idx;
  logic [3:0]    iv_clr;
  logic          os_tick;
  logic          ir_tick;
  logic          ir_light;
  logic          ir_rx_line;
  uia_ir_cfg_s   ir_cfg;

  // byte-lane write merge, used by every writable register except the transmit buffer
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [3:0] sel, input logic [15:0] msk);
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}} & msk;
    merge = (old & ~m) | (d & m);
  endfunction

  // highest-priority pending source, 0 when none, receive first
  function automatic logic [2:0] prio(input logic [3:0] pend);
    prio = 3'd0;
    for (int i = 3; i >= 0; i--) begin
      if (pend[i]) begin
        prio = 3'(i + 1);
      end
    end
  endfunction

  // bus decode: one wait state, ack for every address
  assign acc      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr       = acc && wb_we_i;
  assign rd       = acc && !wb_we_i;
  assign wdat     = wb_dat_i[15:0];
  assign soft_rst = ctrl[CTL_SWRST];
  assign seven    = ctrl[CTL_7BIT];
  assign div_m1   = (bit_div == 16'h0000) ? 16'h0000 : bit_div - 16'h0001;
  assign iv_idx   = prio(flags & int_en);
  assign iv_clr   = (rd && wb_adr_i == ADR_IV && iv_idx != 3'd0) ? 4'(1 << (iv_idx - 3'd1)) : 4'h0;

  // read mux, registered into the data output with ack
  always_comb begin
    unique case (wb_adr_i)
      ADR_CTRL:  rdat = ctrl;
      ADR_BAUD:  rdat = bit_div;
      ADR_RXBUF: rdat = {8'h00, rx_buf};
      ADR_TXBUF: rdat = {8'h00, tx_buf};
      ADR_ABCTL: rdat = ab_ctl;
      ADR_IRCTL: rdat = ir_ctl;
      ADR_IE:    rdat = {12'h000, int_en};
      ADR_IFG:   rdat = {12'h000, flags};
      ADR_IV:    rdat = (iv_idx == 3'd0) ? IV_NONE : {12'h000, iv_idx, 1'b0};
      ADR_STAT:  rdat = {12'h000, fe | oe, oe, fe,
                         (tx_state != TX_IDLE) || (rx_state != RX_IDLE)};
      default:   rdat = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= acc;
      if (rd) begin
        wb_dat_o <= {16'h0000, rdat};
      end
    end
  end

  // control and divisor; autobaud result overrides the divisor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl    <= CTRL_RST;
      bit_div <= BAUD_RST;
    end else if (ce_i) begin
      if (wr && wb_adr_i == ADR_CTRL) begin
        ctrl <= merge(ctrl, wdat, wb_sel_i, CTRL_WMSK);
      end else if (brk_take) begin
        ctrl[CTL_BRK] <= 1'b0;
      end
      if (ab_done) begin
        bit_div <= ab_div;
      end else if (wr && wb_adr_i == ADR_BAUD) begin
        bit_div <= merge(bit_div, wdat, wb_sel_i, 16'hffff);
      end
    end
  end

  // autobaud and infrared settings; error bits set by hardware win over writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ab_ctl <= 16'h0000;
      ir_ctl <= 16'h0000;
    end else if (ce_i) begin
      if (wr && wb_adr_i == ADR_ABCTL) begin
        ab_ctl <= merge(ab_ctl, wdat, wb_sel_i, AB_WMSK);
      end
      if (stoe_set) begin
        ab_ctl[AB_STOE] <= 1'b1;
      end
      if (btoe_set) begin
        ab_ctl[AB_BTOE] <= 1'b1;
      end
      if (wr && wb_adr_i == ADR_IRCTL) begin
        ir_ctl <= merge(ir_ctl, wdat, wb_sel_i, 16'hffff);
      end
    end
  end

  // interrupt enables; soft reset drops receive and transmit enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_en <= 4'h0;
    end else if (ce_i) begin
      if (wr && wb_adr_i == ADR_IE) begin
        int_en <= 4'(merge({12'h000, int_en}, wdat, wb_sel_i, IE_WMSK));
      end
      if (soft_rst) begin
        int_en[IFG_RX] <= 1'b0;
        int_en[IFG_TX] <= 1'b0;
      end
    end
  end

  // flags: software write or clear first, then hardware sets on top
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= IFG_RST;
    end else if (ce_i) begin
      logic [3:0] nf;
      nf = flags & ~iv_clr;
      if (wr && wb_adr_i == ADR_IFG) begin
        nf = 4'(merge({12'h000, flags}, wdat, wb_sel_i, IE_WMSK));
      end
      if (rd && wb_adr_i == ADR_RXBUF) begin
        nf[IFG_RX] = 1'b0;
      end
      if (wr && wb_adr_i == ADR_TXBUF) begin
        nf[IFG_TX] = 1'b0;
      end
      nf[IFG_RX]    = nf[IFG_RX] | rx_done;
      nf[IFG_STT]   = nf[IFG_STT] | start_set;
      nf[IFG_TX]    = nf[IFG_TX] | tx_take;
      nf[IFG_TXCPT] = nf[IFG_TXCPT] | tx_done_set;
      if (soft_rst) begin
        nf[IFG_RX] = 1'b0;
        nf[IFG_TX] = 1'b1;
      end
      flags <= nf;
    end
  end

  // transmit buffer; top bit dropped in seven-bit mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf  <= 8'h00;
      tx_full <= 1'b0;
    end else if (ce_i) begin
      if (wr && wb_adr_i == ADR_TXBUF && wb_sel_i[0]) begin
        tx_buf <= {wdat[7] & !seven, wdat[6:0]};
      end
      tx_full <= !soft_rst && ((wr && wb_adr_i == ADR_TXBUF && wb_sel_i[0]) ||
                               (tx_full && !tx_take));
    end
  end

  // receive buffer and errors; a read clears errors unless a new one lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf <= 8'h00;
      fe     <= 1'b0;
      oe     <= 1'b0;
    end else if (ce_i) begin
      if (rx_done) begin
        rx_buf <= rx_data;
      end
      if (soft_rst) begin
        fe <= 1'b0;
        oe <= 1'b0;
      end else begin
        fe <= (fe && !(rd && wb_adr_i == ADR_RXBUF)) || fe_set;
        oe <= (oe && !(rd && wb_adr_i == ADR_RXBUF)) || (rx_done && flags[IFG_RX]);
      end
    end
  end

  // transmitter hand-off strobes
  assign tx_bit_end  = (tx_cnt == div_m1);
  assign brk_take    = (tx_state == TX_IDLE) && tx_full && ctrl[CTL_BRK] && !soft_rst;
  assign tx_take     = !soft_rst && tx_full &&
                       (((tx_state == TX_IDLE) && !ctrl[CTL_BRK]) ||
                        ((tx_state == TX_DELIM) && tx_bit_end && tx_bits == 5'd0));
  assign tx_done_set = !soft_rst && (tx_state == TX_FRAME) && tx_bit_end &&
                       (tx_bits == 5'd0) && !tx_full;

  // transmit shifter: optional break and delimiter, then start, data lsb first, stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state  <= TX_IDLE;
      tx_cnt    <= 16'h0000;
      tx_bits   <= 5'd0;
      tx_shift  <= 9'h1ff;
      tx_line   <= 1'b1;
      tx_bstart <= 1'b0;
    end else if (ce_i) begin
      tx_bstart <= 1'b0;
      tx_cnt    <= tx_bit_end ? 16'h0000 : tx_cnt + 16'h0001;
      if (soft_rst) begin
        tx_state <= TX_IDLE;
        tx_line  <= 1'b1;
      end else if (tx_take) begin
        tx_state  <= TX_FRAME;
        tx_cnt    <= 16'h0000;
        tx_shift  <= {1'b1, tx_buf[7] | seven, tx_buf[6:0]};
        tx_bits   <= seven ? 5'd8 : 5'd9;
        tx_line   <= 1'b0;
        tx_bstart <= 1'b1;
      end else begin
        unique case (tx_state)
          TX_IDLE: begin
            tx_cnt <= 16'h0000;
            if (brk_take) begin
              tx_state  <= TX_BREAK;
              tx_bits   <= BRK_TX_BITS - 5'd1;
              tx_line   <= 1'b0;
              tx_bstart <= 1'b1;
            end
          end
          TX_BREAK: begin
            if (tx_bit_end) begin
              tx_bstart <= 1'b1;
              tx_bits   <= tx_bits - 5'd1;
              if (tx_bits == 5'd0) begin
                tx_state <= TX_DELIM;
                tx_line  <= 1'b1;
                tx_bits  <= {3'b000, ab_ctl[AB_DELIM_LSB +: 2]};
              end
            end
          end
          TX_DELIM: begin
            if (tx_bit_end) begin
              tx_bits <= tx_bits - 5'd1;
            end
          end
          TX_FRAME: begin
            if (tx_bit_end) begin
              if (tx_bits == 5'd0) begin
                tx_state <= TX_IDLE;
              end else begin
                tx_line   <= tx_shift[0];
                tx_shift  <= {1'b1, tx_shift[8:1]};
                tx_bits   <= tx_bits - 5'd1;
                tx_bstart <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // receiver and autobaud measurement
  assign rx_line    = ir_ctl[IR_EN] ? ir_rx_line : serial_in_pin_i;
  assign fall       = rx_prev && !rx_line;
  assign brk_limit  = 21'(bit_div) * BRK_TOUT_BITS;
  assign brk_min    = 21'(bit_div) * BRK_MIN_BITS;
  assign delim_need = 21'(bit_div) * ({19'h00000, ab_ctl[AB_DELIM_LSB +: 2]} + 21'd1);
  assign rx_data    = (rx_state == AB_SYNC) ? 8'h55 :
                      (seven ? {1'b0, rx_shift[7:1]} : rx_shift);
  // the count stands one short at the closing fall, so one is added back
  assign ab_div     = 16'((rx_cnt + 21'd1) >> SYNC_SHIFT);

  always_comb begin
    rx_done   = 1'b0;
    fe_set    = 1'b0;
    start_set = 1'b0;
    btoe_set  = 1'b0;
    stoe_set  = 1'b0;
    ab_done   = 1'b0;
    if (!soft_rst) begin
      unique case (rx_state)
        RX_START: start_set = (rx_cnt == 21'(bit_div >> 1)) && !rx_line;
        RX_STOP: begin
          rx_done = (rx_cnt == 21'(div_m1));
          fe_set  = rx_done && !rx_line;
        end
        AB_BREAK: btoe_set = (rx_cnt == brk_limit);
        AB_SYNC: begin
          stoe_set = (rx_cnt[20:19] != 2'b00);
          ab_done  = !stoe_set && fall && (ab_falls == SYNC_FALLS - 3'd1);
          rx_done  = ab_done;
        end
        default: rx_done = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 21'd0;
      rx_bits  <= 4'd0;
      rx_shift <= 8'h00;
      ab_falls <= 3'd0;
      rx_prev  <= 1'b1;
    end else if (ce_i) begin
      rx_prev <= rx_line;
      rx_cnt  <= rx_cnt + 21'd1;
      if (soft_rst) begin
        rx_state <= RX_IDLE;
      end else begin
        unique case (rx_state)
          RX_IDLE: begin
            rx_cnt <= 21'd0;
            if (fall) begin
              rx_state <= ab_ctl[AB_EN] ? AB_BREAK : RX_START;
            end
          end
          RX_START: begin
            if (rx_cnt == 21'(bit_div >> 1)) begin
              rx_state <= rx_line ? RX_IDLE : RX_DATA;
              rx_cnt   <= 21'd0;
              rx_bits  <= seven ? 4'd6 : 4'd7;
            end
          end
          RX_DATA: begin
            if (rx_cnt == 21'(div_m1)) begin
              rx_cnt   <= 21'd0;
              rx_shift <= {rx_line, rx_shift[7:1]};
              rx_bits  <= rx_bits - 4'd1;
              if (rx_bits == 4'd0) begin
                rx_state <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_done) begin
              rx_state <= RX_IDLE;
            end
          end
          AB_BREAK: begin
            if (btoe_set) begin
              rx_state <= RX_IDLE;
            end else if (rx_line) begin
              rx_state <= (rx_cnt < brk_min) ? RX_IDLE : AB_DELIM;
              rx_cnt   <= 21'd0;
            end
          end
          AB_DELIM: begin
            if (fall) begin
              rx_state <= (rx_cnt >= delim_need) ? AB_SYNC : RX_IDLE;
              rx_cnt   <= 21'd0;
              ab_falls <= 3'd0;
            end
          end
          AB_SYNC: begin
            if (stoe_set || ab_done) begin
              rx_state <= RX_IDLE;
            end else if (fall) begin
              ab_falls <= ab_falls + 3'd1;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // oversampled bit tick, used as infrared pulse clock when selected and oversampling is on
  assign os_tick = (os_cnt == 12'h000);
  assign ir_tick = (ir_ctl[IR_CLK] && ctrl[CTL_OS16]) ? os_tick : 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      os_cnt <= 12'h000;
    end else if (ce_i) begin
      if (os_tick) begin
        os_cnt <= (bit_div[15:OS_SHIFT] == 12'h000) ? 12'h000 : bit_div[15:OS_SHIFT] - 12'h001;
      end else begin
        os_cnt <= os_cnt - 12'h001;
      end
    end
  end

  assign ir_cfg = '{en: ir_ctl[IR_EN], rx_pol: ir_ctl[IR_RXPL], filt_en: ir_ctl[IR_FE],
                    filt_len: ir_ctl[IR_FL_LSB +: 6], tx_pl: ir_ctl[IR_PL_LSB +: 6]};

  uia_irda u_irda (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .cfg_i          (ir_cfg),
    .tick_i         (ir_tick),
    .bit_div_i      (bit_div),
    .tx_bit_start_i (tx_bstart),
    .tx_bit_i       (tx_line),
    .tx_light_o     (ir_light),
    .rx_pin_i       (serial_in_pin_i),
    .rx_line_o      (ir_rx_line)
  );

  // registered pin and request; codec output only when the codec is enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_out_pin_o <= 1'b1;
      irq_o            <= 1'b0;
    end else if (ce_i) begin
      serial_out_pin_o <= ir_ctl[IR_EN] ? ir_light : tx_line;
      irq_o            <= |(flags & int_en);
    end
  end
endmodule

//--- verif/tb_uart_irda_autobaud_interrupts.sv
module tb_uart_irda_autobaud_interrupts import uia_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [15:0] wd    = 16'h0000;
  logic [15:0] q;
  logic [31:0] rdat;
  logic        ack, line_out, line_in, irq;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          k;
  // address, value written, value read back
  logic [39:0] rows [5] = '{{ADR_ABCTL, 16'hffff, 16'h003d}, {ADR_ABCTL, 16'h0, 16'h0},
    {ADR_IRCTL, 16'hffff, 16'hffff}, {ADR_IRCTL, 16'h0, 16'h0}, {8'hfc, 16'hffff, 16'h0}};
  // 200 MHz
  always #2.5 clk_i = ~clk_i;
  uia_uart dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i({16'h0, wd}), .wb_dat_o(rdat),
    .wb_ack_o(ack), .serial_in_pin_i(line_in), .serial_out_pin_o(line_out), .irq_o(irq));
  uia_node node (.clk_i(clk_i), .line_i(line_out), .line_o(line_in));
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[15:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    chk(q, e);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(ADR_IFG, 16'h0002);
    rc(ADR_IE, 16'h0000);
    rc(ADR_IV, 16'h0000);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence; divisor, autobaud and infrared settings are written only under soft reset
  initial begin
    do_reset();
    foreach (rows[i]) begin
      bus(1'b1, rows[i][39:32], rows[i][31:16]);
      rc(rows[i][39:32], rows[i][15:0]);
    end
    bus(1'b1, ADR_CTRL, 16'h0005);
    bus(1'b1, ADR_TXBUF, 16'h00ff);
    rc(ADR_TXBUF, 16'h007f);
    bus(1'b1, ADR_CTRL, 16'h0000);
    repeat (400) @(posedge clk_i);
    k = node.n;
    bus(1'b1, ADR_TXBUF, 16'h00a5);
    while (node.n == k) @(posedge clk_i);
    chk({8'h00, node.got}, 16'h00a5);
    repeat (40) @(posedge clk_i);
    rc(ADR_IFG, 16'h000a);
    bus(1'b1, ADR_IE, 16'h000f);
    chk({15'h0, irq}, 16'h0001);
    rc(ADR_IV, 16'h0004);
    rc(ADR_IV, 16'h0008);
    node.send(8'h3c);
    repeat (20) @(posedge clk_i);
    rc(ADR_IV, 16'h0002);
    rc(ADR_IV, 16'h0006);
    rc(ADR_IV, 16'h0000);
    rc(ADR_RXBUF, 16'h003c);
    chk({15'h0, irq}, 16'h0000);
    // break, one-bit delimiter, then the synch character
    k = node.n;
    bus(1'b1, ADR_CTRL, 16'h0002);
    bus(1'b1, ADR_TXBUF, 16'h0055);
    while (node.n == k) @(posedge clk_i);
    chk({8'h00, node.got}, 16'h0000);
    while (node.n == k + 1) @(posedge clk_i);
    chk({8'h00, node.got}, 16'h0055);
    // autobaud from a wrong divisor: an overlong break, then a good one
    bus(1'b1, ADR_CTRL, 16'h0001);
    bus(1'b1, ADR_BAUD, 16'h0020);
    bus(1'b1, ADR_ABCTL, 16'h0001);
    bus(1'b1, ADR_CTRL, 16'h0000);
    node.hold(1'b0, 720);
    node.hold(1'b1, 40);
    rc(ADR_ABCTL, 16'h0005);
    node.hold(1'b0, 400);
    node.hold(1'b1, 40);
    node.send(8'h55);
    repeat (20) @(posedge clk_i);
    rc(ADR_BAUD, 16'h0010);
    rc(ADR_RXBUF, 16'h0055);
    do_reset();
    stop_test();
  end
  // watchdog against a hung wait
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end
endmodule

//--- verif/uia_node.sv
module uia_node #(parameter int BIT = 16) (
  // system
  input wire logic clk_i,
  // line
  input wire logic line_i,
  output logic     line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got;
  int         n = 0;
  initial line_o = 1'b1;
  // receiver samples mid-bit, lsb first; frames are counted in n
  always begin
    @(negedge line_i);
    repeat (BIT + BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      got[i] = line_i;
      repeat (BIT) @(posedge clk_i);
    end
    n++;
  end
  // sender: start, eight data bits, stop; line rests high between frames
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      line_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT) @(posedge clk_i);
    end
  endtask
  // hold the line at one level for a number of clocks, for breaks and gaps
  task automatic hold(input logic v, input int c);
    line_o <= v;
    repeat (c) @(posedge clk_i);
  endtask
endmodule

//--- verif/uia_uart_properties.sv
module uia_uart_properties import uia_pkg::*; (
  // system
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins
  input wire logic        serial_out_pin_o,
  input wire logic        irq_o
);
  logic any_wr;
  // until the first write the flag, enable and vector registers must still show their reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) any_wr <= 1'b0;
    else if (wb_cyc_i && wb_stb_i && wb_we_i) any_wr <= 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence fresh(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a && !any_wr;
  endsequence
  ack_next_a: assert property (take |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
  irq_quiet_a: assert property (!any_wr |-> !irq_o) else $error("early irq");
  line_idle_a: assert property (!any_wr |-> serial_out_pin_o) else $error("line busy");
  flags_reset_a: assert property (fresh(ADR_IFG) |-> wb_dat_o[15:0] == 16'h0002)
    else $error("flags reset");
  enables_reset_a: assert property (fresh(ADR_IE) |-> wb_dat_o[15:0] == 16'h0000)
    else $error("enables reset");
  vector_none_a: assert property (fresh(ADR_IV) |-> wb_dat_o[15:0] == IV_NONE)
    else $error("vector reset");
endmodule
bind uia_uart uia_uart_properties chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_out_pin_o(serial_out_pin_o), .irq_o(irq_o));
